// *** inc/spr_map.vh ***
`ifndef SPR_MAP_VH
`define SPR_MAP_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define SPR_IDX_CTRL 16'hfd00
`define SPR_IDX_CLKDIV 16'hfd01
`define SPR_IDX_LLOW 16'hfd02
`define SPR_IDX_LHIGH 16'hfd03
`define SPR_IDX_RLOW 16'hfd04
`define SPR_IDX_RHIGH 16'hfd05
`define SPR_IDX_STAT 16'hfd06
`define SPR_IDX_FRCNT 16'hfd07

// ----------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------
`define SPR_CTRL_EN 3
`define SPR_CTRL_IRQ 1
`define SPR_CTRL_MASK 16'h000a
`define SPR_CTRL_RST 16'h0000
`define SPR_DIV_RST 8'h08
`define SPR_DIV_MIN 8'h04

// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define SPR_ST_CHSCH 15
`define SPR_ST_FRCV 14
`define SPR_ST_MISS 12
`define SPR_ST_BERR 11
`define SPR_ST_FERR 10
`define SPR_ST_SFERR 9
`define SPR_ST_BIPH 8
`define SPR_ST_RIGHT_PARITY_FAIL 7
`define SPR_ST_LEFT_PARITY_FAIL 6
`define SPR_ST_CLR_MASK 16'h9fc0

// ----------------------------------------------------------------
// Stream timing
// ----------------------------------------------------------------
`define SPR_OVERSAMPLE 9'h004
`define SPR_DATA_SLOTS 5'h1c
`define SPR_LAST_FRAME 8'hbf
`define SPR_RUN_MAX 3'h7

`endif

// *** verilog/spr_receiver.v ***
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps
`include "spr_map.vh"

module spr_receiver (
  // Clock and reset
  input wire core_clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_sel_i,
  input wire [17:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Serial audio line
  input wire spdif_i,
  // Frame interrupt request
  output reg irq_o
);

  // ----------------------------------------------------------------
  // Local encodings
  // ----------------------------------------------------------------
  localparam [1:0] ST_SEEK = 2'b00;
  localparam [1:0] ST_PRE = 2'b01;
  localparam [1:0] ST_DATA = 2'b10;
  localparam [1:0] K_NONE = 2'b00;
  localparam [1:0] K_X = 2'b01;
  localparam [1:0] K_Y = 2'b10;
  localparam [1:0] K_Z = 2'b11;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [15:0] ctrl_r;
  reg [7:0] div_r;
  reg [23:0] left_r;
  reg [23:0] right_r;
  reg [15:6] flag_r;
  reg [5:0] vuc_r;
  reg [7:0] fcnt_r;

  // Bus decode; one access is answered per ack, one cycle after request
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr = wb_req & wb_we_i;
  wire bus_rd = wb_req & ~wb_we_i;
  wire [15:0] widx = wb_adr_i[17:2];
  wire [15:0] wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [15:0] wdat = wb_dat_i[15:0];
  wire rx_en = ctrl_r[`SPR_CTRL_EN];

  // ----------------------------------------------------------------
  // Input synchroniser
  // ----------------------------------------------------------------
  reg line_m_r;
  reg line_s_r;

  // Two stages; only the second is read by the decoder
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      line_m_r <= 1'b0;
      line_s_r <= 1'b0;
    end else begin
      line_m_r <= spdif_i;
      line_s_r <= line_m_r;
    end
  end

  // ----------------------------------------------------------------
  // Oversampling tick
  // ----------------------------------------------------------------
  reg [8:0] acc_r;
  reg [8:0] acc_nxt;
  reg tick;
  wire [7:0] div_eff = (div_r < `SPR_DIV_MIN) ? `SPR_DIV_MIN : div_r;

  // Fractional accumulator: adding 4 per clock and wrapping at the divider
  // gives four ticks per bit even when divider/4 is not whole
  always @* begin
    acc_nxt = acc_r + `SPR_OVERSAMPLE;
    tick = 1'b0;
    if (acc_nxt >= {1'b0, div_eff}) begin
      acc_nxt = acc_nxt - {1'b0, div_eff};
      tick = 1'b1;
    end
  end

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_r <= 9'h000;
    end else if (!rx_en) begin
      acc_r <= 9'h000;
    end else begin
      acc_r <= acc_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Run-length measurement in ticks
  // ----------------------------------------------------------------
  reg last_r;
  reg [2:0] run_r;
  reg run_ev;
  reg [1:0] run_u;
  reg run_bad;

  // Runs of 2, 4, 6 ticks are one, two, three half-cells; a run one tick
  // short is also accepted, but any run over 6 ticks is a violation
  always @* begin
    run_ev = tick & (line_s_r != last_r);
    run_bad = 1'b0;
    run_u = 2'd0;
    if (run_r <= 3'd2) begin
      run_u = 2'd1;
    end else if (run_r <= 3'd4) begin
      run_u = 2'd2;
    end else if (run_r <= 3'd6) begin
      run_u = 2'd3;
    end else begin
      run_bad = 1'b1;
    end
    if (tick && line_s_r == last_r && run_r == 3'd6) begin
      run_bad = 1'b1;
    end
  end

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      last_r <= 1'b0;
      run_r <= 3'd1;
    end else if (!rx_en) begin
      last_r <= line_s_r;
      run_r <= 3'd1;
    end else if (tick) begin
      last_r <= line_s_r;
      if (line_s_r != last_r) begin
        run_r <= 3'd1;
      end else if (run_r != `SPR_RUN_MAX) begin
        run_r <= run_r + 3'd1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Subframe decoder
  // ----------------------------------------------------------------
  reg [1:0] state_r;
  reg [1:0] pcnt_r;
  reg [1:0] pr1_r;
  reg [1:0] pr2_r;
  reg [27:0] sr_r;
  reg [4:0] bcnt_r;
  reg half_r;
  reg [1:0] kind_r;
  reg [1:0] prev_r;
  reg zseen_r;
  reg [23:0] lstash_r;
  reg [2:0] lvuc_r;
  reg lpar_r;
  reg lok_r;
  reg set_biph, set_sf, set_fe, set_be, set_lp, set_rp, frame_ev;
  reg [27:0] sr_new;

  // Data bits arrive LSB first: slots 4..27 sample, then V, U, C, parity
  always @* begin
    sr_new = {(half_r & (run_u == 2'd1)), sr_r[27:1]};
  end

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= ST_SEEK;
      pcnt_r <= 2'd0;
      pr1_r <= 2'd0;
      pr2_r <= 2'd0;
      sr_r <= 28'h0000000;
      bcnt_r <= 5'h00;
      half_r <= 1'b0;
      kind_r <= K_NONE;
      prev_r <= K_NONE;
      zseen_r <= 1'b0;
      fcnt_r <= 8'h00;
      lstash_r <= 24'h000000;
      lvuc_r <= 3'b000;
      lpar_r <= 1'b0;
      lok_r <= 1'b0;
      left_r <= 24'h000000;
      right_r <= 24'h000000;
      vuc_r <= 6'h00;
      set_biph <= 1'b0;
      set_sf <= 1'b0;
      set_fe <= 1'b0;
      set_be <= 1'b0;
      set_lp <= 1'b0;
      set_rp <= 1'b0;
      frame_ev <= 1'b0;
    end else if (!rx_en) begin
      state_r <= ST_SEEK;
      half_r <= 1'b0;
      prev_r <= K_NONE;
      zseen_r <= 1'b0;
      fcnt_r <= 8'h00;
      lok_r <= 1'b0;
      set_biph <= 1'b0;
      set_sf <= 1'b0;
      set_fe <= 1'b0;
      set_be <= 1'b0;
      set_lp <= 1'b0;
      set_rp <= 1'b0;
      frame_ev <= 1'b0;
    end else begin
      set_biph <= 1'b0;
      set_sf <= 1'b0;
      set_fe <= 1'b0;
      set_be <= 1'b0;
      set_lp <= 1'b0;
      set_rp <= 1'b0;
      frame_ev <= 1'b0;
      if (run_bad) begin
        // Lost coding: drop lock and wait for the next preamble
        set_biph <= (state_r != ST_SEEK);
        state_r <= ST_SEEK;
        half_r <= 1'b0;
        prev_r <= K_NONE;
      end else if (run_ev) begin
        case (state_r)
          ST_SEEK: begin
            if (run_u == 2'd3) begin
              state_r <= ST_PRE;
              pcnt_r <= 2'd0;
            end
          end
          ST_PRE: begin
            pcnt_r <= pcnt_r + 2'd1;
            pr1_r <= (pcnt_r == 2'd0) ? run_u : pr1_r;
            pr2_r <= (pcnt_r == 2'd1) ? run_u : pr2_r;
            if (pcnt_r == 2'd2) begin
              // Three runs after the leading triple name the preamble
              bcnt_r <= 5'h00;
              half_r <= 1'b0;
              state_r <= ST_DATA;
              if (pr1_r == 2'd3 && pr2_r == 2'd1 && run_u == 2'd1) begin
                kind_r <= K_X;
                prev_r <= K_X;
                fcnt_r <= (fcnt_r == `SPR_LAST_FRAME) ? 8'h00 : fcnt_r + 8'h01;
                set_be <= zseen_r & (fcnt_r == `SPR_LAST_FRAME);
              end else if (pr1_r == 2'd2 && pr2_r == 2'd1 && run_u == 2'd2) begin
                kind_r <= K_Y;
                prev_r <= K_Y;
                set_fe <= (prev_r != K_X) && (prev_r != K_Z);
              end else if (pr1_r == 2'd1 && pr2_r == 2'd1 && run_u == 2'd3) begin
                kind_r <= K_Z;
                prev_r <= K_Z;
                fcnt_r <= 8'h00;
                set_be <= zseen_r & (fcnt_r != `SPR_LAST_FRAME);
                zseen_r <= 1'b1;
              end else begin
                set_biph <= 1'b1;
                state_r <= ST_SEEK;
                prev_r <= K_NONE;
              end
            end
          end
          ST_DATA: begin
            if (run_u == 2'd3) begin
              // A new preamble: the finished subframe must have had 28 bits
              set_sf <= (bcnt_r != `SPR_DATA_SLOTS);
              set_biph <= half_r;
              half_r <= 1'b0;
              state_r <= ST_PRE;
              pcnt_r <= 2'd0;
            end else if (bcnt_r == `SPR_DATA_SLOTS) begin
              // Too many slots in this subframe
              set_sf <= 1'b1;
              state_r <= ST_SEEK;
              prev_r <= K_NONE;
            end else if (run_u == 2'd2 && half_r) begin
              set_biph <= 1'b1;
              state_r <= ST_SEEK;
              prev_r <= K_NONE;
              half_r <= 1'b0;
            end else if (run_u == 2'd1 && !half_r) begin
              half_r <= 1'b1;
            end else begin
              // One slot per bit: full cell is 0, two half-cells are 1
              half_r <= 1'b0;
              sr_r <= sr_new;
              bcnt_r <= bcnt_r + 5'h01;
              if (bcnt_r == `SPR_DATA_SLOTS - 5'h01) begin
                // Channel status bits are passed on raw, no CRC here
                if (kind_r == K_Y) begin
                  set_rp <= ^sr_new;
                  if (lok_r) begin
                    left_r <= lstash_r;
                    right_r <= sr_new[23:0];
                    vuc_r <= {sr_new[24], sr_new[25], sr_new[26], lvuc_r};
                    frame_ev <= 1'b1;
                  end
                  lok_r <= 1'b0;
                end else begin
                  // Validity zero means valid PCM; software judges it
                  lstash_r <= sr_new[23:0];
                  lvuc_r <= {sr_new[24], sr_new[25], sr_new[26]};
                  lpar_r <= ^sr_new;
                  set_lp <= ^sr_new;
                  lok_r <= 1'b1;
                end
              end
            end
          end
          default: begin
            state_r <= ST_SEEK;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  reg [5:0] vuc_old_r;
  reg [15:6] flag_nxt;
  wire stat_wr = bus_wr & (widx == `SPR_IDX_STAT);
  wire lhigh_rd = bus_rd & (widx == `SPR_IDX_LHIGH);
  wire [15:0] clr = stat_wr ? (wmask & ~wdat & `SPR_ST_CLR_MASK) : 16'h0000;
  wire chs_chg = frame_ev & ({vuc_r[3], vuc_r[0]} != {vuc_old_r[3], vuc_old_r[0]});

  // Clears first, sets last, so an event never drops under a clear
  always @* begin
    flag_nxt = flag_r & ~clr[15:6];
    if (lhigh_rd) begin
      flag_nxt[`SPR_ST_FRCV] = 1'b0;
    end
    if (frame_ev) begin
      flag_nxt[`SPR_ST_FRCV] = 1'b1;
    end
    if (frame_ev && flag_r[`SPR_ST_FRCV] && !lhigh_rd) begin
      flag_nxt[`SPR_ST_MISS] = 1'b1;
    end
    if (chs_chg) begin
      flag_nxt[`SPR_ST_CHSCH] = 1'b1;
    end
    if (set_be) flag_nxt[`SPR_ST_BERR] = 1'b1;
    if (set_fe) flag_nxt[`SPR_ST_FERR] = 1'b1;
    if (set_sf) flag_nxt[`SPR_ST_SFERR] = 1'b1;
    if (set_biph) flag_nxt[`SPR_ST_BIPH] = 1'b1;
    if (set_rp) flag_nxt[`SPR_ST_RIGHT_PARITY_FAIL] = 1'b1;
    if (set_lp) flag_nxt[`SPR_ST_LEFT_PARITY_FAIL] = 1'b1;
    flag_nxt[13] = 1'b0;
  end

  // Previous channel status snapshot follows the published one by a cycle
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      flag_r <= 10'h000;
      vuc_old_r <= 6'h00;
      irq_o <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      if (frame_ev) begin
        vuc_old_r <= vuc_r;
      end
      irq_o <= frame_ev & ctrl_r[`SPR_CTRL_IRQ];
    end
  end

  // ----------------------------------------------------------------
  // Wishbone register access
  // ----------------------------------------------------------------
  reg [15:0] rdata;

  // Read mux; unmapped words read zero and accept writes silently
  always @* begin
    case (widx)
      `SPR_IDX_CTRL: rdata = ctrl_r;
      `SPR_IDX_CLKDIV: rdata = {8'h00, div_r};
      `SPR_IDX_LLOW: rdata = {8'h00, left_r[7:0]};
      `SPR_IDX_LHIGH: rdata = left_r[23:8];
      `SPR_IDX_RLOW: rdata = {8'h00, right_r[7:0]};
      `SPR_IDX_RHIGH: rdata = right_r[23:8];
      `SPR_IDX_STAT: rdata = {flag_r, vuc_r};
      `SPR_IDX_FRCNT: rdata = {8'h00, fcnt_r};
      default: rdata = 16'h0000;
    endcase
  end

  // Ack one cycle after the request, dropped the cycle after
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      ctrl_r <= `SPR_CTRL_RST;
      div_r <= `SPR_DIV_RST;
    end else begin
      wb_ack_o <= wb_req;
      if (bus_rd) begin
        wb_dat_o <= {16'h0000, rdata};
      end
      if (bus_wr && widx == `SPR_IDX_CTRL) begin
        ctrl_r <= ((ctrl_r & ~wmask) | (wdat & wmask)) & `SPR_CTRL_MASK;
      end
      if (bus_wr && widx == `SPR_IDX_CLKDIV && wb_sel_i[0]) begin
        div_r <= wdat[7:0];
      end
    end
  end

endmodule

// *** tb/spr_tx_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Biphase-mark audio source, runs continuously like a real link
// ----------------------------------------------------------------
module spr_tx_model #(
  parameter int HALF = 2
) (
  // Clock and serial line
  input wire logic core_clk_i,
  output logic line_o
);
  logic [23:0] left = 24'h0;
  logic [23:0] right = 24'h0;
  logic [2:0] vuc_l = 3'h0;
  logic [2:0] vuc_r = 3'h0;
  bit bad_par_l, bad_par_r, y_for_x, z_now, biph_hit;
  int fcnt = 0;
  event frame_end;
  // One transition, then hold for n half-cells
  task automatic run(input int n);
    line_o <= ~line_o;
    repeat (n * HALF) @(posedge core_clk_i);
  endtask
  // Preamble runs, then 28 one-slot cells LSB first, last is even parity
  task automatic sub(input int pre, input logic [26:0] w, input bit badp, input bit hit);
    logic [15:0] p;
    bit b;
    p = (pre == 0) ? 16'h3311 : (pre == 1) ? 16'h3212 : 16'h3113;
    for (int j = 3; j >= 0; j--) run(p[j*4 +: 4]);
    for (int i = 0; i < 28; i++) begin
      b = (i == 27) ? (^w ^ badp) : w[i];
      if (hit && i == 6) run(5);
      else if (b) begin
        run(1);
        run(1);
      end else run(2);
    end
  endtask
  // Knobs are latched at frame start so the bench never races a frame
  initial begin
    line_o = 1'b0;
    forever begin : frame
      logic [26:0] wl, wr;
      bit pl, pr, hit;
      int pre;
      pre = (fcnt == 0 || z_now) ? 2 : (y_for_x ? 1 : 0);
      wl = {vuc_l[0], vuc_l[1], vuc_l[2], left};
      wr = {vuc_r[0], vuc_r[1], vuc_r[2], right};
      pl = bad_par_l;
      pr = bad_par_r;
      hit = biph_hit;
      {bad_par_l, bad_par_r, y_for_x, z_now, biph_hit} = 5'h0;
      fcnt = (pre == 2) ? 1 : (fcnt + 1) % 192;
      sub(pre, wl, pl, hit);
      sub(1, wr, pr, 1'b0);
      -> frame_end;
    end
  end
endmodule

// *** tb/spr_receiver_asserts.sv ***
`timescale 1ns/1ps
`include "spr_map.vh"
module spr_receiver_asserts (
  // Clock and reset
  input wire core_clk_i,
  input wire rst_i,
  // Register bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_sel_i,
  input wire [17:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // Interrupt
  input wire irq_o
);
  // ----------------------------------------------------------------
  // Shadow of control and of the last status read
  // ----------------------------------------------------------------
  wire acc = wb_cyc_i & wb_stb_i & wb_ack_o;
  wire [15:0] idx = wb_adr_i[17:2];
  reg [3:0] ctrl_r;
  reg [15:0] last_r;
  reg seen_r;
  // A status write voids the sticky comparison
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_r <= 4'h0;
      last_r <= 16'h0;
      seen_r <= 1'b0;
    end else if (acc && idx == `SPR_IDX_CTRL && wb_we_i && wb_sel_i[0]) begin
      ctrl_r <= wb_dat_i[3:0];
    end else if (acc && idx == `SPR_IDX_STAT) begin
      last_r <= wb_dat_o[15:0];
      seen_r <= !wb_we_i;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_rd(logic [15:0] a);
    acc && !wb_we_i && idx == a;
  endsequence
  sequence s_clr;
    acc && wb_we_i && idx == `SPR_IDX_STAT && wb_sel_i[1:0] == 2'b11 && wb_dat_i[15:0] == 16'h0;
  endsequence
  property p_irq_gate;
    irq_o |-> ctrl_r[`SPR_CTRL_IRQ] && $past(ctrl_r[`SPR_CTRL_IRQ]);
  endproperty
  property p_irq_run;
    irq_o |-> $past(ctrl_r[`SPR_CTRL_EN], 2);
  endproperty
  property p_irq_pulse;
    irq_o |=> !irq_o [*8];
  endproperty
  property p_div;
    s_rd(`SPR_IDX_CLKDIV) |-> wb_dat_o[31:8] == 24'h0;
  endproperty
  property p_frcnt;
    s_rd(`SPR_IDX_FRCNT) |-> wb_dat_o < 32'd192;
  endproperty
  property p_frcv;
    s_rd(`SPR_IDX_LHIGH) ##4 s_rd(`SPR_IDX_STAT) |-> !wb_dat_o[`SPR_ST_FRCV];
  endproperty
  property p_wzero;
    s_clr ##4 s_rd(`SPR_IDX_STAT) |-> (wb_dat_o[15:0] & `SPR_ST_CLR_MASK) == 16'h0;
  endproperty
  property p_sticky;
    s_rd(`SPR_IDX_STAT) |-> !seen_r ||
      ((wb_dat_o[15:0] & last_r & `SPR_ST_CLR_MASK) == (last_r & `SPR_ST_CLR_MASK));
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq while disabled");
  a_irq_run: assert property (p_irq_run) else $error("irq while receiver off");
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");
  a_div: assert property (p_div) else $error("divider upper bits set");
  a_frcnt: assert property (p_frcnt) else $error("frame count beyond 191");
  a_frcv: assert property (p_frcv) else $error("frame flag not cleared");
  a_wzero: assert property (p_wzero) else $error("flag not cleared by zero");
  a_sticky: assert property (p_sticky) else $error("sticky flag dropped");
endmodule
bind spr_receiver spr_receiver_asserts spr_receiver_asserts_i (.core_clk_i(core_clk_i),
  .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .irq_o(irq_o));

// *** tb/tb.sv ***
`timescale 1ns/1ps
`include "spr_map.vh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; $display("[ERR] %s expected %h seen %h", n, e, g); end end
module tb;
  // ----------------------------------------------------------------
  // Stimulus, design and source
  // ----------------------------------------------------------------
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [17:0] wb_adr_i = 18'h0;
  logic [31:0] wb_dat_i = 32'h0;
  wire [31:0] wb_dat_o;
  wire wb_ack_o;
  wire irq_o;
  wire spdif_i;
  logic [15:0] v;
  int miscompares = 0;
  int total_checks = 0;
  int irq_cnt = 0;
  spr_receiver spr_receiver_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .spdif_i(spdif_i),
    .irq_o(irq_o));
  // Half-cell of two clocks matches a divider of 4
  spr_tx_model #(.HALF(2)) spr_tx_model_i (.core_clk_i(core_clk_i), .line_o(spdif_i));
  initial forever #4 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) if (irq_o === 1'b1) irq_cnt++;
  // ----------------------------------------------------------------
  // Bus and sequencing helpers
  // ----------------------------------------------------------------
  // Classic cycle held until ack is sampled, then one idle cycle
  task automatic acc(input bit we, input logic [15:0] a, input logic [15:0] d);
    int n = 0;
    @(posedge core_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'h3;
    wb_adr_i <= {a, 2'b00};
    wb_dat_i <= {16'h0, d};
    do @(posedge core_clk_i); while (wb_ack_o !== 1'b1 && ++n < 20);
    if (wb_ack_o !== 1'b1) miscompares++;
    v = wb_dat_o[15:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic rd(input logic [15:0] a); acc(1'b0, a, 16'h0); endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d); acc(1'b1, a, d); endtask
  // The last cell ends only at the next preamble edge; two sync stages,
  // the data load, then the flag update and the irq together add four clocks
  task automatic nxt(input int n);
    repeat (n) @(spr_tx_model_i.frame_end);
    repeat (8) @(posedge core_clk_i);
  endtask
  // Clear, let the frame in flight pass read in time, then the altered one
  task automatic shot();
    wr(`SPR_IDX_STAT, 16'h0);
    rd(`SPR_IDX_LHIGH);
    nxt(1);
    rd(`SPR_IDX_LHIGH);
    nxt(1);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    for (int i = 0; i < 9; i++) begin
      rd(`SPR_IDX_CTRL + i[15:0]);
      `CHK("reset value", (i == 1) ? 16'h0008 : 16'h0000, v);
    end
    wr(`SPR_IDX_LLOW, 16'hffff);
    rd(`SPR_IDX_LLOW);
    `CHK("read-only data", 16'h0000, v);
    wr(`SPR_IDX_CTRL, 16'hffff);
    rd(`SPR_IDX_CTRL);
    `CHK("control bits", `SPR_CTRL_MASK, v);
    wr(`SPR_IDX_CTRL, 16'h0);
    wr(`SPR_IDX_CLKDIV, 16'h0004);
    rd(`SPR_IDX_CLKDIV);
    `CHK("divider", 16'h0004, v);
    $display("registers done");
  endtask
  task automatic t_data();
    wr(`SPR_IDX_CTRL, 16'h000a);
    nxt(3);
    spr_tx_model_i.left = 24'h5a3c96;
    spr_tx_model_i.right = 24'hc3e1f0;
    spr_tx_model_i.vuc_l = 3'b101;
    spr_tx_model_i.vuc_r = 3'b011;
    shot();
    irq_cnt = 0;
    nxt(2);
    `CHK("irq count", 2, irq_cnt);
    rd(`SPR_IDX_LLOW);
    `CHK("left low", 16'h0096, v);
    rd(`SPR_IDX_RLOW);
    `CHK("right low", 16'h00f0, v);
    rd(`SPR_IDX_RHIGH);
    `CHK("right high", 16'hc3e1, v);
    rd(`SPR_IDX_STAT);
    `CHK("status", 16'hd01d, v & 16'hd03f);
    rd(`SPR_IDX_LHIGH);
    `CHK("left high", 16'h5a3c, v);
    rd(`SPR_IDX_STAT);
    `CHK("frame flag", 1'b0, v[14]);
    wr(`SPR_IDX_STAT, 16'h0);
    rd(`SPR_IDX_STAT);
    `CHK("cleared", 16'h0, v & `SPR_ST_CLR_MASK);
    $display("data done");
  endtask
  task automatic t_errors();
    for (int k = 0; k < 2; k++) begin
      spr_tx_model_i.bad_par_l = (k == 0);
      spr_tx_model_i.bad_par_r = (k == 1);
      shot();
      rd(`SPR_IDX_STAT);
      `CHK("parity", k ? 16'h4080 : 16'h4040, v & 16'h50c0);
    end
    spr_tx_model_i.y_for_x = 1'b1;
    shot();
    rd(`SPR_IDX_STAT);
    `CHK("frame error", 1'b1, v[10]);
    spr_tx_model_i.z_now = 1'b1;
    shot();
    rd(`SPR_IDX_FRCNT);
    `CHK("count at block", 16'h0, v);
    rd(`SPR_IDX_STAT);
    `CHK("first block", 1'b0, v[11]);
    nxt(1);
    rd(`SPR_IDX_FRCNT);
    `CHK("count after x", 16'h1, v);
    spr_tx_model_i.z_now = 1'b1;
    shot();
    rd(`SPR_IDX_STAT);
    `CHK("block error", 1'b1, v[11]);
    spr_tx_model_i.biph_hit = 1'b1;
    shot();
    rd(`SPR_IDX_STAT);
    `CHK("biphase error", 1'b1, v[8]);
    $display("errors done");
  endtask
  task automatic t_enables();
    wr(`SPR_IDX_CTRL, 16'h0008);
    irq_cnt = 0;
    nxt(2);
    `CHK("masked irq", 0, irq_cnt);
    wr(`SPR_IDX_CTRL, 16'h0);
    spr_tx_model_i.left = 24'h123456;
    nxt(2);
    rd(`SPR_IDX_LLOW);
    `CHK("held data", 16'h0096, v);
    wr(`SPR_IDX_CTRL, 16'h000a);
    nxt(3);
    rd(`SPR_IDX_LLOW);
    `CHK("relocked data", 16'h0056, v);
    $display("enables done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge core_clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_data();
    t_errors();
    t_enables();
    summarize();
  end
  // Some 27 frames of 256 clocks are expected; allow well over that
  initial begin
    #400000;
    miscompares++;
    $display("watchdog expired");
    summarize();
  end
endmodule
